// File: common/uart_rx_flags_map.svh
/*
 Register offsets, bit positions and reset values of the receive flag block.
 Assumes byte addressing on a 32-bit APB bus, one aligned word per register.
*/
`ifndef UART_RX_FLAGS_MAP_SVH
`define UART_RX_FLAGS_MAP_SVH

// ===========================================================
// Register byte offsets
`define RLC_OFS      8'h00
`define RHB_OFS      8'h04
`define CTRL_OFS     8'h08
`define IRQ_STAT_OFS 8'h0C
`define IRQ_EN_OFS   8'h10
`define IRQ_CLR_OFS  8'h14

// ===========================================================
// Field positions
`define PENDING_BIT  0
`define OVERRUN_BIT  1
`define FIFO_EN_BIT  0
`define EV_DATA_BIT  0
`define EV_OVR_BIT   1

// ===========================================================
// Reset values
`define CTRL_RST     1'h0
`define IRQ_RST      2'h0
`define PRDATA_RST   32'h0000_0000

`endif

// File: common/uart_rx_flags_pkg.sv
/*
 Types shared by the receive flag block.
 Assumes the map header supplies all numeric constants.
*/
package uart_rx_flags_pkg;

	// ===========================================================
	// Bus word and event vector
	typedef logic [31:0] apb_word_t;
	typedef logic [1:0]  rx_event_t;

endpackage

// File: hdl/uart_rx_overrun_ready_flags.sv
/*
 Receive line-condition flags (data pending and overrun) of one serial channel,
 with an APB register slave and a level interrupt.
 Assumes the receive shifter and FIFO run on pclk and drive their strobes
 synchronously; the FIFO shows its head word while not empty.
*/
// Chosen here: the address map and the APB interface to the registers.
// Summary of operation
// - Without FIFO, a character loaded over an unread one raises overrun.
// - Without FIFO, the new character always replaces the held one.
// - A host read of the receive line condition register clears overrun.
// - With FIFO, overrun comes only from a full FIFO plus a finished character.
// - With FIFO, a character finished while the FIFO is full is never pushed.
// - Overrun is set at the stop-bit time of the offending character.
// - Overrun is zero after reset and until an overrun occurs.
// - Data pending goes to one once a character sits in the buffer or FIFO.
// - Data pending drops only when the buffer or the whole FIFO is read out, or when a CTRL write changes the mode.
// - Data pending is zero after reset and while nothing waits.

`include "uart_rx_flags_map.svh"

module uart_rx_overrun_ready_flags #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 8
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Receive shifter
	input  wire logic              rx_char_stop,
	input  wire logic [DATA_W-1:0] rx_char_data,
	// Receive FIFO
	input  wire logic              rx_fifo_full,
	input  wire logic              rx_fifo_empty,
	input  wire logic [DATA_W-1:0] rx_fifo_data,
	output logic                   rx_fifo_push,
	output logic                   rx_fifo_pop,
	output logic                   rx_fifo_enable,
	// Interrupt
	output logic                   irq
);

	// ===========================================================
	// Elaboration checks
	if (ADDR_W < 8 || ADDR_W > 32)
	begin : g_bad_addr
		$error("ADDR_W must lie between 8 and 32");
	end
	if (DATA_W < 5 || DATA_W > 8)
	begin : g_bad_data
		$error("DATA_W must lie between 5 and 8");
	end

	// ===========================================================
	// State
	logic                        fifo_mode;
	logic                        overrun;
	logic                        holding_full;
	logic [DATA_W-1:0]           receive_holding_buffer;
	uart_rx_flags_pkg::rx_event_t irq_status;
	uart_rx_flags_pkg::rx_event_t irq_enable;
	logic                        rx_pending_flag;
	logic [7:0]                  receive_line_condition;
	uart_rx_flags_pkg::rx_event_t events;

	// ===========================================================
	// Bus phase decode
	wire setup_ph  = psel & ~penable;
	wire access_ph = psel & penable;
	wire wr_acc    = access_ph & pwrite;
	wire rd_acc    = access_ph & ~pwrite;

	// Address match, full width so aliases stay unmapped
	wire sel_rlc   = paddr == ADDR_W'(`RLC_OFS);
	wire sel_rhb   = paddr == ADDR_W'(`RHB_OFS);
	wire sel_ctrl  = paddr == ADDR_W'(`CTRL_OFS);
	wire sel_stat  = paddr == ADDR_W'(`IRQ_STAT_OFS);
	wire sel_en    = paddr == ADDR_W'(`IRQ_EN_OFS);
	wire sel_clr   = paddr == ADDR_W'(`IRQ_CLR_OFS);
	wire mapped    = sel_rlc | sel_rhb | sel_ctrl | sel_stat | sel_en | sel_clr;

	// Side-effect strobes, all taken at the access edge
	wire rlc_rd    = rd_acc & sel_rlc;
	wire rhb_rd    = rd_acc & sel_rhb;
	wire ctrl_wr   = wr_acc & sel_ctrl;
	wire en_wr     = wr_acc & sel_en;
	wire clr_wr    = wr_acc & sel_clr;

	// Zero-wait slave; unmapped access answers with an error
	assign pready  = 1'b1;
	assign pslverr = access_ph & ~mapped;

	// ===========================================================
	// Receive path steering
	// Without FIFO every finished character lands in the buffer
	wire load_hold = rx_char_stop & ~fifo_mode;
	wire hold_rd   = rhb_rd & ~fifo_mode;

	// A read in the same cycle takes the old word, so no loss
	wire ovr_buf   = load_hold & holding_full & ~hold_rd;
	// Passing the trigger level is not an overrun, only a full FIFO is
	wire ovr_fifo  = rx_char_stop & fifo_mode & rx_fifo_full;
	wire ovr_set   = ovr_buf | ovr_fifo;

	// The finished character is dropped instead of pushed when full
	assign rx_fifo_push   = rx_char_stop & fifo_mode & ~rx_fifo_full;
	assign rx_fifo_pop    = rhb_rd & fifo_mode & ~rx_fifo_empty;
	assign rx_fifo_enable = fifo_mode;

	// Set wins over clear so an overrun in the read cycle survives
	wire next_overrun      = ovr_set | (overrun & ~rlc_rd);
	wire next_holding_full = load_hold | (holding_full & ~hold_rd);

	// Pending follows the buffer or the FIFO occupancy
	assign rx_pending_flag = fifo_mode ? ~rx_fifo_empty : holding_full;

	// ===========================================================
	// Line condition word, reserved bits read zero
	always_comb
	begin
		receive_line_condition = 8'h00;
		receive_line_condition[`PENDING_BIT] = rx_pending_flag;
		receive_line_condition[`OVERRUN_BIT] = overrun;
	end

	// Event vector for the interrupt status
	always_comb
	begin
		events = `IRQ_RST;
		events[`EV_DATA_BIT] = load_hold | rx_fifo_push;
		events[`EV_OVR_BIT]  = ovr_set;
	end

	// ===========================================================
	// Interrupt logic
	wire [1:0] clr_mask    = clr_wr ? pwdata[1:0] : 2'h0;
	wire [1:0] next_status = events | (irq_status & ~clr_mask);
	assign irq = |(irq_status & irq_enable);

	// ===========================================================
	// Read data selection
	wire [31:0] rd_char = {{(32 - DATA_W){1'b0}},
		fifo_mode ? rx_fifo_data : receive_holding_buffer};
	wire [31:0] rd_mux =
		sel_rlc  ? {24'h00_0000, receive_line_condition} :
		sel_rhb  ? rd_char :
		sel_ctrl ? {31'h0000_0000, fifo_mode} :
		sel_stat ? {30'h0000_0000, irq_status} :
		sel_en   ? {30'h0000_0000, irq_enable} :
		`PRDATA_RST;

	// ===========================================================
	// Flag registers
	// Writes to the line condition offset have no path here
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			overrun      <= 1'b0;
			holding_full <= 1'b0;
		end
		else
		begin
			overrun      <= next_overrun;
			holding_full <= next_holding_full;
		end
	end

	// Buffer word, overwritten even if unread
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			receive_holding_buffer <= '0;
		else if (load_hold)
			receive_holding_buffer <= rx_char_data;
	end

	// Control and interrupt registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fifo_mode  <= `CTRL_RST;
			irq_enable <= `IRQ_RST;
			irq_status <= `IRQ_RST;
		end
		else
		begin
			if (ctrl_wr)
				fifo_mode <= pwdata[`FIFO_EN_BIT];
			if (en_wr)
				irq_enable <= pwdata[1:0];
			irq_status <= next_status;
		end
	end

	// Read data captured in the setup cycle, held through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= `PRDATA_RST;
		else if (setup_ph & ~pwrite)
			prdata <= rd_mux;
	end

	// ===========================================================
	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Unread buffer overwritten raises overrun
	a_ovr_buffer_load: assert property (
		load_hold && holding_full && !hold_rd |=> overrun)
		else $error("buffer overrun not flagged");

	// Buffer always takes the newest character
	a_buf_takes_new: assert property (
		load_hold |=> receive_holding_buffer == $past(rx_char_data))
		else $error("buffer not replaced");

	// Status read clears overrun unless a new one arrives
	a_ovr_read_clear: assert property (
		rlc_rd && !ovr_set |=> !overrun)
		else $error("overrun not cleared by read");

	// FIFO with room never creates overrun
	a_fifo_room_quiet: assert property (
		fifo_mode && !rx_fifo_full && !ovr_set |=>
		overrun == ($past(overrun) && !$past(rlc_rd)))
		else $error("overrun without full FIFO");

	// Full FIFO never receives a push
	a_full_no_push: assert property (
		rx_fifo_full |-> !rx_fifo_push)
		else $error("push into full FIFO");

	// Stop bit with full FIFO flags overrun next cycle
	a_ovr_fifo_stop: assert property (
		rx_char_stop && fifo_mode && rx_fifo_full |=> overrun)
		else $error("FIFO overrun not flagged");

	// Overrun only rises from an overrun event
	a_ovr_has_cause: assert property (
		$rose(overrun) |-> $past(ovr_set))
		else $error("overrun rose without cause");

	// Finished character in buffer mode shows pending
	a_pending_set: assert property (
		load_hold |=> rx_pending_flag [*1] ##1 1'b1)
		else $error("pending not set");

	// Buffer read with no new character drops pending
	a_pending_drop: assert property (
		hold_rd && !load_hold ##1 !fifo_mode |-> !rx_pending_flag)
		else $error("pending not dropped");

	// Empty FIFO shows nothing pending
	a_fifo_empty_idle: assert property (
		fifo_mode && rx_fifo_empty |-> !rx_pending_flag)
		else $error("pending while FIFO empty");

	// Writes to the status offset leave overrun alone
	a_lsr_write_ro: assert property (
		wr_acc && sel_rlc && !ovr_set |=> overrun == $past(overrun))
		else $error("status write changed overrun");

	// An enabled overrun event raises the interrupt next cycle
	a_irq_level: assert property (
		ovr_set && irq_enable[`EV_OVR_BIT] && !en_wr |=> irq)
		else $error("interrupt missing");

	// Only a status read may drop a standing overrun
	a_ovr_stays_set: assert property (
		overrun && !rlc_rd |=> overrun)
		else $error("overrun dropped without read");

	// No event, no overrun
	a_ovr_stays_zero: assert property (
		!overrun && !ovr_set |=> !overrun)
		else $error("overrun set without event");

	// Finished character with room goes into the FIFO
	a_fifo_push_room: assert property (
		rx_char_stop && fifo_mode && !rx_fifo_full |-> rx_fifo_push)
		else $error("character not pushed");

	// Pending stays while the FIFO holds data
	a_pending_fifo: assert property (
		fifo_mode && !rx_fifo_empty |-> rx_pending_flag)
		else $error("pending dropped with FIFO data");

	// Unread buffer keeps pending up
	a_pending_hold: assert property (
		!fifo_mode && holding_full && !hold_rd && !ctrl_wr |=> rx_pending_flag)
		else $error("pending dropped without read");

	// Pops only come from a FIFO that holds data
	a_pop_has_data: assert property (
		rx_fifo_pop |-> fifo_mode && !rx_fifo_empty)
		else $error("pop from empty FIFO");

endmodule

// File: sim/rx_fifo_model.sv
/*
 Behavioural receive FIFO standing behind the flag block.
 Assumes push and pop are single-cycle strobes on pclk.
*/
module rx_fifo_model #(
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Strobes and data
	input  wire logic       push,
	input  wire logic       pop,
	input  wire logic [7:0] din,
	output logic            full,
	output logic            empty,
	output logic [7:0]      dout
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [DEPTH];
	logic [7:0] last;
	int         cnt;
	// Empty head shows the complement of the last popped word, never the stale word
	assign full  = (cnt == DEPTH);
	assign empty = (cnt == 0);
	assign dout  = empty ? ~last : mem[0];
	// Push at a full FIFO is dropped unless a pop in the same cycle makes room
	always @(posedge pclk or negedge presetn)
	begin : upd
		logic [7:0] m [DEPTH];
		int         n;
		m = mem;
		n = cnt;
		if (!presetn)
			n = 0;
		else
		begin
			if (pop && n != 0)
			begin
				last <= m[0];
				for (int i = 0; i < DEPTH - 1; i++)
					m[i] = m[i + 1];
				n--;
			end
			if (push && n != DEPTH)
			begin
				m[n] = din;
				n++;
			end
		end
		mem <= m;
		cnt <= n;
	end
endmodule

// File: sim/testbench.sv
/*
 Self-checking bench for the receive flag block.
 Assumes zero-wait APB answers and a two-deep FIFO model.
*/
`include "uart_rx_flags_map.svh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00, cdat = 8'h00, fdat;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, cstop = 1'h0, ffull, fempty, fpush, fpop, fen, irq, e;
	int errors = 0, comparisons = 0, push_err = 0;
	// ===========================================================
	// Clock, design and FIFO
	always #12.5 pclk = ~pclk;
	uart_rx_overrun_ready_flags uart_rx_overrun_ready_flags_i (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_char_stop(cstop), .rx_char_data(cdat),
		.rx_fifo_full(ffull), .rx_fifo_empty(fempty), .rx_fifo_data(fdat),
		.rx_fifo_push(fpush), .rx_fifo_pop(fpop), .rx_fifo_enable(fen), .irq(irq));
	rx_fifo_model rx_fifo_model_i (.pclk(pclk), .presetn(presetn), .push(fpush),
		.pop(fpop), .din(cdat), .full(ffull), .empty(fempty), .dout(fdat));
	// A push into a full FIFO would lose the held order
	always @(posedge pclk)
		if (fpush === 1'h1 && ffull === 1'h1)
			push_err++;
	// ===========================================================
	// Tasks
	task automatic end_sim();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	// Setup, access until pready, then release and let an edge pass
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic er);
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
		apb(a, 1'h0, 32'h0, q, e);
		chk(n, x, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'h1, d, q, e);
	endtask
	task automatic ch(input logic [7:0] d);
		cstop <= 1'h1;
		cdat <= d;
		@(posedge pclk);
		cstop <= 1'h0;
		cdat <= ~d;
		@(posedge pclk);
	endtask
	// Irq is looked at mid-cycle, away from the launching edge
	task automatic chk_irq(input logic x);
		@(negedge pclk);
		chk("irq", {31'h0, x}, {31'h0, irq});
		@(posedge pclk);
	endtask
	// ===========================================================
	// Watchdog and tests
	initial
	begin
		repeat (5000) @(posedge pclk);
		errors++;
		end_sim();
	end
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rd(`RLC_OFS, 32'h0, "rlc reset");
		rd(`CTRL_OFS, 32'h0, "ctrl reset");
		wr(`RLC_OFS, 32'h3);
		rd(`RLC_OFS, 32'h0, "rlc written");
		ch(8'hA5);
		rd(`RLC_OFS, 32'h1, "rlc one char");
		ch(8'h3C);
		rd(`RLC_OFS, 32'h3, "rlc overrun");
		rd(`RLC_OFS, 32'h1, "rlc after read");
		rd(`RHB_OFS, 32'h3C, "rhb newest");
		rd(`RLC_OFS, 32'h0, "rlc emptied");
		rd(`IRQ_STAT_OFS, 32'h3, "irq status");
		chk_irq(1'h0);
		wr(`IRQ_EN_OFS, 32'h2);
		chk_irq(1'h1);
		wr(`IRQ_CLR_OFS, 32'h2);
		chk_irq(1'h0);
		rd(`IRQ_STAT_OFS, 32'h1, "irq status cleared");
		wr(`IRQ_EN_OFS, 32'h3);
		chk_irq(1'h1);
		wr(`IRQ_CLR_OFS, 32'h3);
		chk_irq(1'h0);
		apb(8'h18, 1'h1, 32'h0, q, e);
		chk("unmapped", 32'h1, {31'h0, e});
		wr(`CTRL_OFS, 32'h1);
		chk("fifo enable", 32'h1, {31'h0, fen});
		ch(8'h11);
		rd(`RLC_OFS, 32'h1, "fifo one char");
		ch(8'h22);
		ch(8'h33);
		rd(`RLC_OFS, 32'h3, "fifo overrun");
		rd(`RHB_OFS, 32'h11, "fifo head");
		rd(`RLC_OFS, 32'h1, "fifo one left");
		rd(`RHB_OFS, 32'h22, "fifo second");
		rd(`RLC_OFS, 32'h0, "fifo drained");
		chk("full push", 32'h0, push_err);
		end_sim();
	end
endmodule
